// [core/crfs_change_det.sv]
`timescale 1ns/10ps

module crfs_change_det (
   // states
   input  wire logic [1:0] old_state,
   input  wire logic [1:0] new_state,
   // sensitivity
   input  wire logic [1:0] sens,
   // result
   output logic            report
);

   function automatic logic is_off(input logic [1:0] s);
      is_off = (s == 2'(crfs_pkg::CRFS_ST_OFF));
   endfunction : is_off

   always_comb begin
      case (crfs_pkg::crfs_sens_e'(sens))
         crfs_pkg::CRFS_SENS_NONE: report = 1'b0;
         crfs_pkg::CRFS_SENS_BOFF: report = is_off(old_state) != is_off(new_state);
         crfs_pkg::CRFS_SENS_ERR:  report = (old_state[1] != new_state[1])
                                           | (is_off(old_state) != is_off(new_state));
         default:                  report = old_state != new_state;
      endcase
   end

endmodule : crfs_change_det

// [core/crfs_flags.sv]
`timescale 1ns/10ps
`include "crfs_map.svh"

// Summary of operation
// - flags clear by writing one, only once the setting cause is gone, or in init mode even while the cause remains
// - each flag has an enable bit masking its interrupt request
// - flag writes only outside init mode; one clears, zero ignored; states read-only
// - both init signals high forces flags to reset; writable when both low
// - rx_state and tx_state keep tracking during init mode
// - sleep with wake_enable and bus activity sets wake_flag; raises wake request
// - bus status change sets status_change_flag; raises error request
// - states frozen while status_change_flag pending; update after clearing
// - rx_state 00 below 96, 01 below 128, 10 above, 11 bus-off
// - tx_state 00 when transmit error count below 96
// - bus-off only above 255, forces rx_state off; exit returns to the level set by the counters
// - receive overrun sets overrun_flag; raises error request
// - correct message shifted into foreground buffer sets rx_full_flag
// - no foreground shift while rx_full_flag set; software clears to release
// - rx_full_flag set and unmasked raises receive request
// - sensitivity fields select which state changes set status_change_flag
module crfs_flags #(
   parameter int ADDR_W = 8,
   parameter int TEC_W  = 9,
   parameter int REC_W  = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [7:0]             rdata,
   // mode controls
   input  wire logic              init_request,
   input  wire logic              init_acknowledge,
   input  wire logic              sleep_mode,
   input  wire logic              wake_enable,
   // bus events
   input  wire logic              bus_activity,
   input  wire logic              overrun_event,
   input  wire logic [TEC_W-1:0]  tx_error_counter,
   input  wire logic [REC_W-1:0]  rx_error_counter,
   // receive fifo
   input  wire logic              fifo_entry_valid,
   output logic                   fg_shift,
   // interrupt requests
   output logic                   wake_irq,
   output logic                   err_irq,
   output logic                   rx_irq
);

   generate
      if (TEC_W < 9 || REC_W < 8 || ADDR_W < 3) begin : g_bad_params
         $error("crfs_flags: counters need 9/8 bits, address at least 3");
      end
      // thresholds are compared as 32-bit values
      if (TEC_W > 32 || REC_W > 32) begin : g_wide_cnt
         $error("crfs_flags: counters wider than 32 bits are not supported");
      end
   endgenerate

   logic                      init_mode;
   logic                      wr_open;
   logic                      wr_flags;
   logic                      wr_enab;
   logic [7:0]                clr;

   logic                      wake_q;
   logic                      csc_q;
   logic                      ovr_q;
   logic                      rxf_q;
   logic [1:0]                rx_state_q;
   logic [1:0]                tx_state_q;
   logic [7:0]                enab_q;
   logic                      shift_q;
   logic [7:0]                rdata_q;
   logic                      wake_irq_q;
   logic                      err_irq_q;
   logic                      rx_irq_q;

   crfs_pkg::crfs_bus_state_e rx_code;
   crfs_pkg::crfs_bus_state_e tx_code;
   logic                      rx_rep;
   logic                      tx_rep;
   logic                      st_upd;
   logic                      csc_set;
   logic                      wake_set;
   logic                      shift_d;
   logic [7:0]                flags_rd;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      addr_hit = (a == ADDR_W'(ofs));
   endfunction : addr_hit

   // init mode when both handshakes high
   assign init_mode = init_request & init_acknowledge;
   assign wr_open   = ~init_request & ~init_acknowledge;
   assign wr_flags  = ce & wr & wr_open & addr_hit(addr, `CRFS_RECEIVER_FLAGS_OFS);
   assign wr_enab   = ce & wr & wr_open & addr_hit(addr, `CRFS_RX_IRQ_ENABLE_OFS);
   assign clr       = wr_flags ? wdata : 8'h00;

   crfs_state_enc #(
      .TEC_W (TEC_W),
      .REC_W (REC_W)
   ) u_enc (
      .tx_error_counter (tx_error_counter),
      .rx_error_counter (rx_error_counter),
      .rx_code          (rx_code),
      .tx_code          (tx_code)
   );

   crfs_change_det u_rx_det (
      .old_state (rx_state_q),
      .new_state (rx_code),
      .sens      (enab_q[`CRFS_RSENS_HI:`CRFS_RSENS_LO]),
      .report    (rx_rep)
   );

   crfs_change_det u_tx_det (
      .old_state (tx_state_q),
      .new_state (tx_code),
      .sens      (enab_q[`CRFS_TSENS_HI:`CRFS_TSENS_LO]),
      .report    (tx_rep)
   );

   // hold states while flag pending
   // a clear with a change pending reloads at once and re-flags if the sensitivity selects it
   assign st_upd  = (~csc_q | clr[`CRFS_CSC_BIT] | init_mode)
                    & ((rx_state_q != rx_code) | (tx_state_q != tx_code));
   assign csc_set = st_upd & (rx_rep | tx_rep) & ~init_mode;
   assign wake_set = sleep_mode & wake_enable & bus_activity;
   // no shift while buffer full
   // shift_q also blocks the cycle before the flag rises
   assign shift_d = fifo_entry_valid & ~rxf_q & ~shift_q & ~init_mode;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_state_q <= 2'h0;
      end else if (ce && st_upd) begin
         rx_state_q <= rx_code;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_state_q <= 2'h0;
      end else if (ce && st_upd) begin
         tx_state_q <= tx_code;
      end
   end

   // wake flag, set wins over clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_q <= 1'b0;
      end else if (ce) begin
         if (init_mode) begin
            wake_q <= 1'b0;
         end else if (wake_set) begin
            wake_q <= 1'b1;
         end else if (clr[`CRFS_WAKE_BIT]) begin
            wake_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         csc_q <= 1'b0;
      end else if (ce) begin
         if (init_mode) begin
            csc_q <= 1'b0;
         end else if (csc_set) begin
            csc_q <= 1'b1;
         end else if (clr[`CRFS_CSC_BIT]) begin
            // new change in clear cycle wins
            csc_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovr_q <= 1'b0;
      end else if (ce) begin
         if (init_mode) begin
            ovr_q <= 1'b0;
         end else if (overrun_event) begin
            ovr_q <= 1'b1;
         end else if (clr[`CRFS_OVR_BIT]) begin
            ovr_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxf_q <= 1'b0;
      end else if (ce) begin
         if (init_mode) begin
            rxf_q <= 1'b0;
         end else if (shift_q) begin
            rxf_q <= 1'b1;
         end else if (clr[`CRFS_RXF_BIT]) begin
            rxf_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shift_q <= 1'b0;
      end else if (ce) begin
         shift_q <= shift_d;
      end
   end

   // enable register, held in reset during init
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         enab_q <= `CRFS_RX_IRQ_ENABLE_RST;
      end else if (ce) begin
         if (init_mode) begin
            enab_q <= `CRFS_RX_IRQ_ENABLE_RST;
         end else if (wr_enab) begin
            enab_q <= wdata;
         end
      end
   end

   assign flags_rd = {wake_q, csc_q, rx_state_q, tx_state_q, ovr_q, rxf_q};

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         if (!rd) begin
            rdata_q <= 8'h00;
         end else if (addr_hit(addr, `CRFS_RECEIVER_FLAGS_OFS)) begin
            rdata_q <= flags_rd;
         end else if (addr_hit(addr, `CRFS_RX_IRQ_ENABLE_OFS)) begin
            rdata_q <= enab_q;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   // masked wake request, registered so outputs are glitch free
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_irq_q <= 1'b0;
      end else if (ce) begin
         wake_irq_q <= wake_q & enab_q[`CRFS_WAKE_IE_BIT];
      end
   end

   // masked error request
   // one error request shared by two causes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_irq_q <= 1'b0;
      end else if (ce) begin
         err_irq_q <= (csc_q & enab_q[`CRFS_CSC_IE_BIT])
                      | (ovr_q & enab_q[`CRFS_OVR_IE_BIT]);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_irq_q <= 1'b0;
      end else if (ce) begin
         rx_irq_q <= rxf_q & enab_q[`CRFS_RXF_IE_BIT];
      end
   end

   assign rdata    = rdata_q;
   assign fg_shift = shift_q;
   assign wake_irq = wake_irq_q;
   assign err_irq  = err_irq_q;
   assign rx_irq   = rx_irq_q;

endmodule : crfs_flags

// [core/crfs_state_enc.sv]
`timescale 1ns/10ps
`include "crfs_map.svh"

module crfs_state_enc #(
   parameter int TEC_W = 9,
   parameter int REC_W = 8
) (
   // error counters
   input  wire logic [TEC_W-1:0]       tx_error_counter,
   input  wire logic [REC_W-1:0]       rx_error_counter,
   // derived codes
   output crfs_pkg::crfs_bus_state_e   rx_code,
   output crfs_pkg::crfs_bus_state_e   tx_code
);

   function automatic crfs_pkg::crfs_bus_state_e level(input logic [31:0] cnt);
      if (cnt < `CRFS_WARN_LIMIT) begin
         level = crfs_pkg::CRFS_ST_OK;
      end else if (cnt < `CRFS_ERR_LIMIT) begin
         level = crfs_pkg::CRFS_ST_WARN;
      end else begin
         level = crfs_pkg::CRFS_ST_ERR;
      end
   endfunction : level

   logic [31:0] tec_w;
   logic [31:0] rec_w;
   logic        boff;

   assign tec_w = 32'(tx_error_counter);
   assign rec_w = 32'(rx_error_counter);
   assign boff  = (tec_w >= `CRFS_BOFF_LIMIT);

   assign rx_code = boff ? crfs_pkg::CRFS_ST_OFF : level(rec_w);
   assign tx_code = boff ? crfs_pkg::CRFS_ST_OFF : level(tec_w);

endmodule : crfs_state_enc

// [shared/crfs_map.svh]
`ifndef CRFS_MAP_SVH
`define CRFS_MAP_SVH

// register offsets
`define CRFS_RECEIVER_FLAGS_OFS 8'h04
`define CRFS_RX_IRQ_ENABLE_OFS  8'h05

// reset values
`define CRFS_RECEIVER_FLAGS_RST 8'h00
`define CRFS_RX_IRQ_ENABLE_RST  8'h00

// receiver_flags field positions
`define CRFS_WAKE_BIT   7
`define CRFS_CSC_BIT    6
`define CRFS_RXST_HI    5
`define CRFS_RXST_LO    4
`define CRFS_TXST_HI    3
`define CRFS_TXST_LO    2
`define CRFS_OVR_BIT    1
`define CRFS_RXF_BIT    0

// rx_irq_enable_reg field positions
`define CRFS_WAKE_IE_BIT 7
`define CRFS_CSC_IE_BIT  6
`define CRFS_RSENS_HI    5
`define CRFS_RSENS_LO    4
`define CRFS_TSENS_HI    3
`define CRFS_TSENS_LO    2
`define CRFS_OVR_IE_BIT  1
`define CRFS_RXF_IE_BIT  0

// error counter thresholds
`define CRFS_WARN_LIMIT  96
`define CRFS_ERR_LIMIT   128
`define CRFS_BOFF_LIMIT  256

`endif

// [shared/crfs_pkg.sv]
package crfs_pkg;

   typedef enum logic [1:0] {
      CRFS_ST_OK   = 2'b00,
      CRFS_ST_WARN = 2'b01,
      CRFS_ST_ERR  = 2'b10,
      CRFS_ST_OFF  = 2'b11
   } crfs_bus_state_e;

   typedef enum logic [1:0] {
      CRFS_SENS_NONE = 2'b00,
      CRFS_SENS_BOFF = 2'b01,
      CRFS_SENS_ERR  = 2'b10,
      CRFS_SENS_ALL  = 2'b11
   } crfs_sens_e;

endpackage : crfs_pkg

// [verif/crfs_can_src.sv]
`timescale 1ns/10ps

module crfs_can_src (
   // clock and reset
   input wire logic  clk,
   input wire logic  arst_n,
   // stimulus and handshake
   input wire logic  push,
   input wire logic  fg_shift,
   output logic      fifo_entry_valid,
   output logic [3:0] taken_q
);
   logic [3:0] pend_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_q  <= 4'h0;
         taken_q <= 4'h0;
      end else begin
         pend_q  <= pend_q + 4'(push) - 4'(fg_shift);
         taken_q <= taken_q + 4'(fg_shift);
      end
   end
   assign fifo_entry_valid = (pend_q != 4'h0);
endmodule : crfs_can_src

// [verif/crfs_flags_asserts.sv]
`timescale 1ns/10ps

module crfs_flags_chk #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic              ce,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0]        wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [7:0]        rdata,
   // modes, fifo, requests
   input wire logic              init_request,
   input wire logic              init_acknowledge,
   input wire logic              fifo_entry_valid,
   input wire logic              fg_shift,
   input wire logic              wake_irq,
   input wire logic              err_irq,
   input wire logic              rx_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   wire  init_both = init_request && init_acknowledge;
   wire  idle_mode = !init_request && !init_acknowledge;
   logic held_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         held_q <= 1'b0;
      else if (ce && init_both)
         held_q <= 1'b0;
      else if (ce && fg_shift)
         held_q <= 1'b1;
      else if (ce && wr && idle_mode && addr == 8'h04 && wdata[0])
         held_q <= 1'b0;
   end

   chk_rdata_idle: assert property (ce && !rd |=> rdata == 8'h00)
      else $error("read data not idle");
   chk_rd_unmapped: assert property (ce && rd && addr != 8'h04 && addr != 8'h05
      |=> rdata == 8'h00) else $error("unmapped read not zero");
   chk_shift_pulse: assert property (ce && fg_shift |=> !fg_shift)
      else $error("shift longer than one cycle");
   chk_shift_cause: assert property (fg_shift |-> $past(fifo_entry_valid))
      else $error("shift without waiting entry");
   chk_no_reshift: assert property (held_q |-> !fg_shift)
      else $error("shift while buffer full");
   chk_shift_taken: assert property (ce && fifo_entry_valid && !held_q
      && !fg_shift && idle_mode |=> fg_shift) else $error("entry not shifted");
   chk_rx_irq_cause: assert property (rx_irq |-> $past(held_q))
      else $error("receive request without full buffer");
   chk_init_quiet: assert property (ce && init_both ##1 ce && init_both
      |=> !wake_irq && !err_irq && !rx_irq) else $error("request during init");
endmodule : crfs_flags_chk

bind crfs_flags crfs_flags_chk #(.ADDR_W(ADDR_W)) u_chk (.clk, .arst_n, .ce, .addr,
   .wdata, .wr, .rd, .rdata, .init_request, .init_acknowledge, .fifo_entry_valid,
   .fg_shift, .wake_irq, .err_irq, .rx_irq);

// [verif/crfs_flags_bench.sv]
`timescale 1ns/10ps

module crfs_flags_bench;
   logic       clk, arst_n, ce, wr, rd, init_request, init_acknowledge;
   logic       sleep_mode, wake_enable, bus_activity, overrun_event, push;
   logic [7:0] addr, wdata, rx_error_counter;
   logic [8:0] tx_error_counter;
   wire  [7:0] rdata;
   wire  [3:0] taken_q;
   wire        fifo_entry_valid, fg_shift, wake_irq, err_irq, rx_irq;
   int         num_errors = 0;
   int         tests_run = 0;

   crfs_flags u_dut (.clk, .arst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .init_request,
      .init_acknowledge, .sleep_mode, .wake_enable, .bus_activity, .overrun_event,
      .tx_error_counter, .rx_error_counter, .fifo_entry_valid, .fg_shift, .wake_irq,
      .err_irq, .rx_irq);
   crfs_can_src u_src (.clk, .arst_n, .push, .fg_shift, .fifo_entry_valid, .taken_q);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask : rd_reg

   task automatic cnt(input logic [8:0] t, input logic [7:0] r);
      @(posedge clk);
      tx_error_counter <= t;
      rx_error_counter <= r;
      cyc(3);
   endtask : cnt

   // counters, then flags and error request, then clear
   task automatic step(input logic [8:0] t, input logic [7:0] r, input logic [7:0] e);
      cnt(t, r);
      rd_reg(8'h04, e);
      chk({7'h0, err_irq}, {7'h0, e[6]});
      wr_reg(8'h04, 8'h40);
   endtask : step

   initial begin
      {ce, arst_n, wr, rd, init_request, init_acknowledge} = 6'h20;
      {sleep_mode, wake_enable, bus_activity, overrun_event, push} = 5'h00;
      addr = 8'h00;
      wdata = 8'h00;
      tx_error_counter = 9'h000;
      rx_error_counter = 8'h00;
      cyc(16);
      arst_n <= 1'b1;
      rd_reg(8'h04, 8'h00);
      rd_reg(8'h05, 8'h00);
      rd_reg(8'h07, 8'h00);
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'h05, 8'h40 | 8'(s << 4) | 8'(s << 2));
         step(9'd0, 8'd96, {1'b0, s == 3, 6'h10});
         step(9'd0, 8'd128, {1'b0, s >= 2, 6'h20});
         step(9'd256, 8'd128, {1'b0, s >= 1, 6'h3c});
         step(9'd0, 8'd0, {1'b0, s >= 1, 6'h00});
      end
      cnt(9'd96, 8'd0);
      rd_reg(8'h04, 8'h44);
      cnt(9'd96, 8'd128);
      rd_reg(8'h04, 8'h44);
      wr_reg(8'h04, 8'h40);
      rd_reg(8'h04, 8'h64);
      cnt(9'd0, 8'd0);
      wr_reg(8'h04, 8'h40);
      rd_reg(8'h04, 8'h40);
      wr_reg(8'h04, 8'h40);
      wr_reg(8'h05, 8'h01);
      @(posedge clk);
      push <= 1'b1;
      cyc(2);
      push <= 1'b0;
      cyc(6);
      rd_reg(8'h04, 8'h01);
      chk({4'h0, taken_q}, 8'h01);
      chk({7'h0, rx_irq}, 8'h01);
      wr_reg(8'h04, 8'h00);
      rd_reg(8'h04, 8'h01);
      wr_reg(8'h04, 8'h01);
      cyc(6);
      @(negedge clk);
      chk({4'h0, taken_q}, 8'h02);
      wr_reg(8'h04, 8'h01);
      cyc(3);
      rd_reg(8'h04, 8'h00);
      chk({7'h0, rx_irq}, 8'h00);
      wr_reg(8'h05, 8'h82);
      @(posedge clk);
      overrun_event <= 1'b1;
      wr_reg(8'h04, 8'h02);
      overrun_event <= 1'b0;
      rd_reg(8'h04, 8'h02);
      chk({7'h0, err_irq}, 8'h01);
      wr_reg(8'h04, 8'h02);
      rd_reg(8'h04, 8'h00);
      @(posedge clk);
      sleep_mode <= 1'b1;
      bus_activity <= 1'b1;
      cyc(2);
      rd_reg(8'h04, 8'h00);
      @(posedge clk);
      wake_enable <= 1'b1;
      cyc(2);
      bus_activity <= 1'b0;
      rd_reg(8'h04, 8'h80);
      chk({7'h0, wake_irq}, 8'h01);
      wr_reg(8'h04, 8'h80);
      rd_reg(8'h04, 8'h00);
      @(posedge clk);
      overrun_event <= 1'b1;
      init_request <= 1'b1;
      @(posedge clk);
      overrun_event <= 1'b0;
      wr_reg(8'h04, 8'h02);
      rd_reg(8'h04, 8'h02);
      @(posedge clk);
      init_acknowledge <= 1'b1;
      cnt(9'd0, 8'd96);
      rd_reg(8'h04, 8'h10);
      wr_reg(8'h05, 8'hff);
      rd_reg(8'h05, 8'h00);
      @(posedge clk);
      {init_request, init_acknowledge} <= 2'b00;
      wr_reg(8'h04, 8'hff);
      rd_reg(8'h04, 8'h10);
      wr_reg(8'h05, 8'h82);
      rd_reg(8'h05, 8'h82);
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(8'h05, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      rd_reg(8'h05, 8'h82);
      complete_run();
   end

   // whole sequence needs about three hundred cycles
   initial begin
      #200us;
      num_errors++;
      complete_run();
   end
endmodule : crfs_flags_bench
